// ### design/wake_pkg.sv
// Operation
// - wake enable set: normal receive blocked, only the detector sees data
// - detection notifies host via interrupt or power event, as programmed
// - detection sets the wake pattern received status bit
// - clearing wake enable returns to normal frame reception
// - only frames to station, broadcast or multicast address are examined
// - after both address fields, search for six consecutive 0xFF bytes
// - sixteen back-to-back station address copies after the run declare detection
// - broken copy sequence restarts the 0xFF run search in the frame
// - run and copies may start anywhere after the address fields; copies need the run first
// - multicast destination frames are also examined for the copies
// - station address is 48 bits over low and high registers
// - host writes address registers; eeprom loader fills them at power-on
// - each loader byte 01h-06h goes to host and fabric pause address registers
// - loader bytes 01h-04h fill low, 05h-06h fill high, first byte lowest
package wake_pkg;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0]  OFS_HOST_LOW  = 8'h00;
   localparam logic [7:0]  OFS_HOST_HIGH = 8'h04;
   localparam logic [7:0]  OFS_FAB_LOW   = 8'h08;
   localparam logic [7:0]  OFS_FAB_HIGH  = 8'h0C;
   localparam logic [7:0]  OFS_WUCSR     = 8'h10;
   localparam logic [7:0]  OFS_INT_STS   = 8'h14;
   localparam logic [7:0]  OFS_INT_MASK  = 8'h18;

   // wake control and status fields
   localparam int          BIT_WAKE_EN   = 0;
   localparam int          BIT_WAKE_RCV  = 1;
   localparam int          BIT_IRQ_EN    = 2;
   localparam int          BIT_PME_EN    = 3;
   localparam int          WUCSR_W       = 4;
   // interrupt status fields
   localparam int          BIT_EV_WAKE   = 0;
   localparam int          BIT_EV_LOAD   = 1;
   localparam int          EV_W          = 2;

   localparam logic [47:0] ADDR_RST      = 48'h0000_0000_0000;
   localparam logic [47:0] BCAST_ADDR    = 48'hFFFF_FFFF_FFFF;
   localparam logic [3:0]  WUCSR_RST     = 4'h0;
   localparam logic [1:0]  EV_RST        = 2'h0;

   // ****************************************
   // frame scan constants
   // ****************************************
   localparam logic [7:0]  SYNC_BYTE     = 8'hFF;
   localparam logic [2:0]  SYNC_LEN      = 3'h6;
   localparam logic [3:0]  DA_LAST       = 4'h5;
   localparam logic [3:0]  HDR_LAST      = 4'hB;
   localparam logic [2:0]  ADDR_BYTE_LAST = 3'h5;
   localparam logic [3:0]  COPY_LAST     = 4'hF;
   localparam logic [7:0]  EE_FIRST      = 8'h01;
   localparam logic [7:0]  EE_LAST       = 8'h06;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_DEST = 3'h1,
      ST_SRC  = 3'h3,
      ST_SYNC = 3'h2,
      ST_COPY = 3'h6,
      ST_HIT  = 3'h7
   } scan_state_t;

   typedef struct packed {
      logic       valid;
      logic       first;
      logic       last;
      logic [7:0] data;
   } rx_byte_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] addr;
      logic [7:0] data;
   } ee_byte_t;

endpackage

// ### design/wake_pattern_detector_addr.sv
`timescale 1ns/10ps
module wake_pattern_detector_addr (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             srst,
   // register port
   input  wire logic [7:0]       reg_addr,
   input  wire logic [31:0]      reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic [31:0]           reg_rdata,
   // frames from the fabric
   input  wire wake_pkg::rx_byte_t rx_in,
   // frames to normal reception
   output wake_pkg::rx_byte_t    rx_out,
   // eeprom loader bytes
   input  wire wake_pkg::ee_byte_t ee_in,
   // addresses and notifications
   output logic [47:0]           fabric_pause_addr,
   output logic [47:0]           station_addr,
   output logic                  irq,
   output logic                  power_event_out
);

   // ****************************************
   // register state
   // ****************************************
   logic [47:0]                  host_addr_reg,  host_addr_next;
   logic [47:0]                  fab_addr_reg,   fab_addr_next;
   logic [3:0]                   wucsr_reg,      wucsr_next;
   logic [1:0]                   sts_reg,        sts_next;
   logic [1:0]                   mask_reg,       mask_next;
   logic [31:0]                  rdata_reg,      rdata_next;
   logic                         irq_reg,        irq_next;
   logic                         pme_reg,        pme_next;

   // ****************************************
   // scan state
   // ****************************************
   wake_pkg::scan_state_t        st_reg,         st_next;
   logic [3:0]                   cnt_reg,        cnt_next;
   logic [2:0]                   ff_reg,         ff_next;
   logic [2:0]                   bidx_reg,       bidx_next;
   logic [3:0]                   copy_reg,       copy_next;
   logic                         da_st_reg,      da_st_next;
   logic                         da_bc_reg,      da_bc_next;
   logic                         da_mc_reg,      da_mc_next;
   logic                         hit;

   // ****************************************
   // receive path state
   // ****************************************
   logic                         mode_reg,       mode_next;
   logic                         in_frame_reg,   in_frame_next;
   wake_pkg::rx_byte_t           out_reg,        out_next;

   logic [7:0]                   exp_byte;
   logic [7:0]                   bc_byte;
   logic [2:0]                   ee_idx;
   logic                         ee_hit;

   assign exp_byte = host_addr_reg[{bidx_reg, 3'b000} +: 8];
   assign bc_byte  = wake_pkg::BCAST_ADDR[{cnt_reg[2:0], 3'b000} +: 8];
   assign ee_idx   = 3'(ee_in.addr - wake_pkg::EE_FIRST);
   assign ee_hit   = ee_in.valid && ee_in.addr >= wake_pkg::EE_FIRST
                     && ee_in.addr <= wake_pkg::EE_LAST;

   // ****************************************
   // registers: next values
   // ****************************************
   always_comb begin
      host_addr_next = host_addr_reg;
      fab_addr_next  = fab_addr_reg;
      wucsr_next     = wucsr_reg;
      sts_next       = sts_reg;
      mask_next      = mask_reg;
      rdata_next     = 32'h0000_0000;
      if (reg_wr) begin
         case (reg_addr)
            wake_pkg::OFS_HOST_LOW:  host_addr_next[31:0]  = reg_wdata;
            wake_pkg::OFS_HOST_HIGH: host_addr_next[47:32] = reg_wdata[15:0];
            wake_pkg::OFS_FAB_LOW:   fab_addr_next[31:0]   = reg_wdata;
            wake_pkg::OFS_FAB_HIGH:  fab_addr_next[47:32]  = reg_wdata[15:0];
            wake_pkg::OFS_WUCSR: begin
               wucsr_next[wake_pkg::BIT_WAKE_EN] = reg_wdata[wake_pkg::BIT_WAKE_EN];
               wucsr_next[wake_pkg::BIT_IRQ_EN]  = reg_wdata[wake_pkg::BIT_IRQ_EN];
               wucsr_next[wake_pkg::BIT_PME_EN]  = reg_wdata[wake_pkg::BIT_PME_EN];
               if (reg_wdata[wake_pkg::BIT_WAKE_RCV]) begin
                  wucsr_next[wake_pkg::BIT_WAKE_RCV] = 1'b0;
               end
            end
            wake_pkg::OFS_INT_STS:   sts_next  = sts_reg & ~reg_wdata[1:0];
            wake_pkg::OFS_INT_MASK:  mask_next = reg_wdata[1:0];
            default: begin
            end
         endcase
      end
      if (ee_hit) begin
         host_addr_next[{ee_idx, 3'b000} +: 8] = ee_in.data;
         fab_addr_next[{ee_idx, 3'b000} +: 8]  = ee_in.data;
      end
      if (ee_hit && ee_in.addr == wake_pkg::EE_LAST) begin
         sts_next[wake_pkg::BIT_EV_LOAD] = 1'b1;
      end
      if (hit) begin
         wucsr_next[wake_pkg::BIT_WAKE_RCV] = 1'b1;
         sts_next[wake_pkg::BIT_EV_WAKE]    = 1'b1;
      end
      if (reg_rd) begin
         case (reg_addr)
            wake_pkg::OFS_HOST_LOW:  rdata_next = host_addr_reg[31:0];
            wake_pkg::OFS_HOST_HIGH: rdata_next = {16'h0000, host_addr_reg[47:32]};
            wake_pkg::OFS_FAB_LOW:   rdata_next = fab_addr_reg[31:0];
            wake_pkg::OFS_FAB_HIGH:  rdata_next = {16'h0000, fab_addr_reg[47:32]};
            wake_pkg::OFS_WUCSR:     rdata_next = {28'h000_0000, wucsr_reg};
            wake_pkg::OFS_INT_STS:   rdata_next = {30'h0000_0000, sts_reg};
            wake_pkg::OFS_INT_MASK:  rdata_next = {30'h0000_0000, mask_reg};
            default:                 rdata_next = 32'h0000_0000;
         endcase
      end
      irq_next = (wucsr_next[wake_pkg::BIT_WAKE_RCV] && wucsr_next[wake_pkg::BIT_IRQ_EN])
                 || |(sts_next & mask_next);
      pme_next = wucsr_next[wake_pkg::BIT_WAKE_RCV] && wucsr_next[wake_pkg::BIT_PME_EN];
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         host_addr_reg <= wake_pkg::ADDR_RST;
         fab_addr_reg  <= wake_pkg::ADDR_RST;
         wucsr_reg     <= wake_pkg::WUCSR_RST;
         sts_reg       <= wake_pkg::EV_RST;
         mask_reg      <= wake_pkg::EV_RST;
         rdata_reg     <= 32'h0000_0000;
         irq_reg       <= 1'b0;
         pme_reg       <= 1'b0;
      end else begin
         host_addr_reg <= host_addr_next;
         fab_addr_reg  <= fab_addr_next;
         wucsr_reg     <= wucsr_next;
         sts_reg       <= sts_next;
         mask_reg      <= mask_next;
         rdata_reg     <= rdata_next;
         irq_reg       <= irq_next;
         pme_reg       <= pme_next;
      end
   end

   // ****************************************
   // receive path: mode switch at frame gaps
   // ****************************************
   always_comb begin
      mode_next     = mode_reg;
      in_frame_next = in_frame_reg;
      out_next      = '0;
      if (rx_in.valid) begin
         in_frame_next = !rx_in.last;
      end
      if (!in_frame_reg && !(rx_in.valid && !rx_in.first)) begin
         mode_next = wucsr_reg[wake_pkg::BIT_WAKE_EN];
      end
      // normal reception blocked in wake mode
      if (!mode_next) begin
         out_next = rx_in;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         mode_reg     <= 1'b0;
         in_frame_reg <= 1'b0;
         out_reg      <= '0;
      end else begin
         mode_reg     <= mode_next;
         in_frame_reg <= in_frame_next;
         out_reg      <= out_next;
      end
   end

   // ****************************************
   // pattern scan: next values
   // ****************************************
   always_comb begin
      st_next    = st_reg;
      cnt_next   = cnt_reg;
      ff_next    = ff_reg;
      bidx_next  = bidx_reg;
      copy_next  = copy_reg;
      da_st_next = da_st_reg;
      da_bc_next = da_bc_reg;
      da_mc_next = da_mc_reg;
      hit        = 1'b0;
      if (rx_in.valid && mode_next) begin
         if (rx_in.first) begin
            cnt_next   = 4'h1;
            da_st_next = rx_in.data == host_addr_reg[7:0];
            da_bc_next = rx_in.data == wake_pkg::BCAST_ADDR[7:0];
            da_mc_next = rx_in.data[0];
            st_next    = wake_pkg::ST_DEST;
         end else begin
            case (st_reg)
               wake_pkg::ST_DEST: begin
                  cnt_next   = cnt_reg + 4'h1;
                  da_st_next = da_st_reg
                               && rx_in.data == host_addr_reg[{cnt_reg[2:0], 3'b000} +: 8];
                  da_bc_next = da_bc_reg && rx_in.data == bc_byte;
                  if (cnt_reg == wake_pkg::DA_LAST) begin
                     st_next = (da_st_next || da_bc_next || da_mc_reg)
                               ? wake_pkg::ST_SRC : wake_pkg::ST_IDLE;
                  end
               end
               wake_pkg::ST_SRC: begin
                  cnt_next = cnt_reg + 4'h1;
                  if (cnt_reg == wake_pkg::HDR_LAST) begin
                     st_next = wake_pkg::ST_SYNC;
                     ff_next = 3'h0;
                  end
               end
               wake_pkg::ST_SYNC: begin
                  // copies only after a full run
                  if (ff_reg == wake_pkg::SYNC_LEN && rx_in.data == host_addr_reg[7:0]) begin
                     st_next   = wake_pkg::ST_COPY;
                     bidx_next = 3'h1;
                     copy_next = 4'h0;
                  end else if (rx_in.data == wake_pkg::SYNC_BYTE) begin
                     if (ff_reg != wake_pkg::SYNC_LEN) begin
                        ff_next = ff_reg + 3'h1;
                     end
                  end else begin
                     ff_next = 3'h0;
                  end
               end
               wake_pkg::ST_COPY: begin
                  if (rx_in.data == exp_byte) begin
                     if (bidx_reg == wake_pkg::ADDR_BYTE_LAST) begin
                        bidx_next = 3'h0;
                        copy_next = copy_reg + 4'h1;
                        if (copy_reg == wake_pkg::COPY_LAST) begin
                           hit     = 1'b1;
                           st_next = wake_pkg::ST_HIT;
                        end
                     end else begin
                        bidx_next = bidx_reg + 3'h1;
                     end
                  end else begin
                     st_next = wake_pkg::ST_SYNC;
                     ff_next = (rx_in.data == wake_pkg::SYNC_BYTE) ? 3'h1 : 3'h0;
                  end
               end
               wake_pkg::ST_HIT: begin
               end
               default: st_next = wake_pkg::ST_IDLE;
            endcase
         end
         if (rx_in.last) begin
            st_next = wake_pkg::ST_IDLE;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         st_reg    <= wake_pkg::ST_IDLE;
         cnt_reg   <= 4'h0;
         ff_reg    <= 3'h0;
         bidx_reg  <= 3'h0;
         copy_reg  <= 4'h0;
         da_st_reg <= 1'b0;
         da_bc_reg <= 1'b0;
         da_mc_reg <= 1'b0;
      end else begin
         st_reg    <= st_next;
         cnt_reg   <= cnt_next;
         ff_reg    <= ff_next;
         bidx_reg  <= bidx_next;
         copy_reg  <= copy_next;
         da_st_reg <= da_st_next;
         da_bc_reg <= da_bc_next;
         da_mc_reg <= da_mc_next;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign reg_rdata         = rdata_reg;
   assign rx_out            = out_reg;
   assign fabric_pause_addr = fab_addr_reg;
   assign station_addr      = host_addr_reg;
   assign irq               = irq_reg;
   assign power_event_out   = pme_reg;

endmodule

// ### sim/wake_checker.sv
`timescale 1ns/10ps
module wake_checker (
   // clock and reset
   input wire logic               clock,
   input wire logic               srst,
   // register port
   input wire logic [7:0]         reg_addr,
   input wire logic [31:0]        reg_wdata,
   input wire logic               reg_wr,
   input wire logic               reg_rd,
   input wire logic [31:0]        reg_rdata,
   // frames and loader
   input wire wake_pkg::rx_byte_t rx_in,
   input wire wake_pkg::rx_byte_t rx_out,
   input wire wake_pkg::ee_byte_t ee_in,
   // addresses and notifications
   input wire logic [47:0]        fabric_pause_addr,
   input wire logic [47:0]        station_addr,
   input wire logic               irq,
   input wire logic               power_event_out
);
   // ****************************************
   // port relations
   // ****************************************
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);

   chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
      else $error("read data not idle");
   chk_unmapped_zero: assert property (reg_rd && reg_addr == 8'h1C |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   chk_high_pad: assert property (reg_rd && reg_addr == wake_pkg::OFS_HOST_HIGH
      |=> reg_rdata[31:16] == 16'h0000) else $error("high register pad not zero");
   chk_rx_copy: assert property (rx_out.valid |-> $past(rx_in.valid)
      && rx_out.data == $past(rx_in.data) && rx_out.first == $past(rx_in.first)
      && rx_out.last == $past(rx_in.last))
      else $error("passed byte not a copy of input");
   chk_ee_first: assert property (ee_in.valid && ee_in.addr == 8'h01 |=>
      station_addr[7:0] == $past(ee_in.data) && fabric_pause_addr[7:0] == $past(ee_in.data))
      else $error("loader first byte misplaced");
   chk_ee_last: assert property (ee_in.valid && ee_in.addr == 8'h06 |=>
      station_addr[47:40] == $past(ee_in.data) && fabric_pause_addr[47:40] == $past(ee_in.data))
      else $error("loader last byte misplaced");
   chk_ee_ignore: assert property (ee_in.valid && (ee_in.addr == 8'h00 || ee_in.addr > 8'h06)
      && !reg_wr |=> $stable(fabric_pause_addr) && $stable(station_addr))
      else $error("loader byte outside range written");
   chk_addr_cause: assert property (!$stable(station_addr) |-> $past(ee_in.valid) || $past(reg_wr))
      else $error("station address changed without cause");
   chk_pme_sticky: assert property (power_event_out && !reg_wr |=> power_event_out)
      else $error("power event dropped without write");
   chk_irq_fall: assert property ($fell(irq) |-> $past(reg_wr))
      else $error("interrupt dropped without write");
   chk_pme_rise: assert property ($rose(power_event_out) |-> $past(rx_in.valid)
      || $past(reg_wr)) else $error("power event without cause");
   chk_irq_rise: assert property ($rose(irq) |-> $past(rx_in.valid)
      || $past(ee_in.valid) || $past(reg_wr)) else $error("interrupt without cause");
endmodule

// ### sim/fabric_model.sv
`timescale 1ns/10ps
module fabric_model (
   // clock
   input  wire logic          clock,
   // frame bytes toward the detector
   output wake_pkg::rx_byte_t rx
);
   initial rx = '0;
   task automatic send(input logic [7:0] q[$], input int gap);
      for (int i = 0; i < q.size(); i++) begin
         @(posedge clock);
         rx <= {1'b1, i == 0, i == q.size() - 1, q[i]};
         // idle cycles show a changed byte
         repeat (gap) begin
            @(posedge clock);
            rx <= {3'b000, ~q[i]};
         end
      end
      @(posedge clock);
      rx <= {3'b000, ~q[q.size() - 1]};
   endtask
endmodule

// ### sim/wake_pattern_detector_addr_tb.sv
`timescale 1ns/10ps
module wake_pattern_detector_addr_tb;
   logic               clock, srst, reg_wr, reg_rd, irq, power_event_out;
   logic [7:0]         reg_addr;
   logic [31:0]        reg_wdata, reg_rdata, rd_val;
   logic [47:0]        fabric_pause_addr, station_addr;
   wake_pkg::rx_byte_t rx_in, rx_out;
   wake_pkg::ee_byte_t ee_in;
   int                 num_errors, comparisons, rx_seen;
   logic [7:0]         fr[$];
   localparam logic [47:0] STA = 48'hBC9A_7856_3412;

   wake_pattern_detector_addr u_wake_pattern_detector_addr (.clock(clock), .srst(srst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .rx_in(rx_in), .rx_out(rx_out), .ee_in(ee_in),
      .fabric_pause_addr(fabric_pause_addr), .station_addr(station_addr), .irq(irq),
      .power_event_out(power_event_out));
   fabric_model u_fabric_model (.clock(clock), .rx(rx_in));

   always #2 clock = ~clock;
   always @(posedge clock) if (rx_out.valid === 1'b1) rx_seen++;

   // ****************************************
   // shared tasks
   // ****************************************
   task check(input logic [47:0] seen, input logic [47:0] exp, input string msg);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
      check(rd_val, exp, msg);
   endtask
   task ee(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      ee_in <= {1'b1, a, d};
      @(posedge clock);
      ee_in <= '0;
   endtask
   task settle;
      @(posedge clock);
      #1;
   endtask
   // header, run of pre sync bytes, n1 copies, optional break, run and n2 copies
   task frame(input logic [47:0] da, input int pre, input int n1, input int n2, input int gap);
      fr = {};
      for (int b = 0; b < 6; b++) fr.push_back(da[8*b +: 8]);
      repeat (6) fr.push_back(8'h5A);
      repeat (pre) fr.push_back(8'hFF);
      repeat (n1) for (int b = 0; b < 6; b++) fr.push_back(STA[8*b +: 8]);
      if (n2 > 0) begin
         fr.push_back(8'h00);
         repeat (6) fr.push_back(8'hFF);
         repeat (n2) for (int b = 0; b < 6; b++) fr.push_back(STA[8*b +: 8]);
      end
      fr.push_back(8'h00);
      u_fabric_model.send(fr, gap);
      repeat (4) @(posedge clock);
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task t_host;
      rd_chk(wake_pkg::OFS_WUCSR, 32'h0, "control not zero");
      rd_chk(8'h1C, 32'h0, "unmapped read");
      wr(wake_pkg::OFS_HOST_LOW, 32'h3322_1100);
      wr(wake_pkg::OFS_HOST_HIGH, 32'hFFFF_5544);
      wr(wake_pkg::OFS_FAB_LOW, 32'hA1B2_C3D4);
      rd_chk(wake_pkg::OFS_HOST_HIGH, 32'h0000_5544, "host high");
      rd_chk(wake_pkg::OFS_FAB_LOW, 32'hA1B2_C3D4, "fabric low");
      check(station_addr, 48'h5544_3322_1100, "station after host write");
   endtask
   task t_loader;
      wr(wake_pkg::OFS_INT_MASK, 32'h2);
      for (int i = 1; i < 8; i++) ee(i[7:0], (i == 7) ? 8'hEE : STA[8*(i-1) +: 8]);
      settle();
      check(station_addr, STA, "loaded station");
      check(fabric_pause_addr, STA, "loaded fabric copy");
      check(irq, 1'b1, "loader interrupt");
      rd_chk(wake_pkg::OFS_HOST_LOW, 32'h7856_3412, "low byte order");
      rd_chk(wake_pkg::OFS_INT_STS, 32'h2, "loader status");
      wr(wake_pkg::OFS_INT_STS, 32'h2);
      settle();
      check(irq, 1'b0, "interrupt after clear");
      wr(wake_pkg::OFS_INT_MASK, 32'h0);
      ee(8'h06, STA[47:40]);
      settle();
      check(irq, 1'b0, "masked interrupt");
      wr(wake_pkg::OFS_INT_STS, 32'h2);
   endtask
   task t_normal;
      rx_seen = 0;
      frame(wake_pkg::BCAST_ADDR, 6, 16, 0, 0);
      check(rx_seen, 48'd115, "normal reception count");
   endtask
   task t_wake;
      wr(wake_pkg::OFS_WUCSR, 32'h5);
      repeat (2) @(posedge clock);
      rx_seen = 0;
      frame(48'h0000_0000_0002, 6, 16, 0, 0);
      check(irq, 1'b0, "other unicast examined");
      frame(STA, 0, 16, 0, 0);
      check(irq, 1'b0, "copies without run");
      frame(STA, 8, 15, 16, 1);
      check(irq, 1'b1, "pattern after restart");
      check(rx_seen, 48'd0, "bytes passed in wake mode");
      rd_chk(wake_pkg::OFS_WUCSR, 32'h7, "received bit");
      rd_chk(wake_pkg::OFS_INT_STS, 32'h1, "wake event status");
      check(irq, 1'b1, "interrupt held");
      wr(wake_pkg::OFS_WUCSR, 32'h7);
      settle();
      check(irq, 1'b0, "interrupt after clear");
      rd_chk(wake_pkg::OFS_WUCSR, 32'h5, "received bit cleared");
   endtask
   task t_bcast;
      wr(wake_pkg::OFS_INT_STS, 32'h1);
      wr(wake_pkg::OFS_INT_MASK, 32'h1);
      wr(wake_pkg::OFS_WUCSR, 32'h1);
      repeat (2) @(posedge clock);
      frame(wake_pkg::BCAST_ADDR, 0, 16, 0, 0);
      check(irq, 1'b0, "broadcast copies without run");
      frame(wake_pkg::BCAST_ADDR, 6, 16, 0, 0);
      check(irq, 1'b1, "broadcast pattern");
      check(power_event_out, 1'b0, "power event not enabled");
      rd_chk(wake_pkg::OFS_INT_STS, 32'h1, "broadcast wake event");
      wr(wake_pkg::OFS_INT_STS, 32'h1);
      settle();
      check(irq, 1'b0, "wake event cleared");
      wr(wake_pkg::OFS_WUCSR, 32'h3);
      wr(wake_pkg::OFS_INT_MASK, 32'h0);
      rd_chk(wake_pkg::OFS_WUCSR, 32'h1, "broadcast received bit cleared");
   endtask
   task t_mcast;
      wr(wake_pkg::OFS_WUCSR, 32'h9);
      frame(48'h0000_0000_0001, 6, 15, 0, 0);
      check(power_event_out, 1'b0, "fifteen copies");
      frame(48'h0000_0000_0001, 6, 16, 0, 0);
      check(power_event_out, 1'b1, "multicast pattern");
      check(irq, 1'b0, "interrupt not enabled");
      wr(wake_pkg::OFS_WUCSR, 32'h2);
      settle();
      check(power_event_out, 1'b0, "power event after clear");
      repeat (2) @(posedge clock);
      rx_seen = 0;
      frame(STA, 6, 1, 0, 0);
      check(rx_seen, 48'd25, "reception resumed");
   endtask

   task report_and_stop;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      clock = 1'b0;
      srst = 1'b1;
      {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
      ee_in = '0;
      repeat (8) @(posedge clock);
      srst <= 1'b0;
      t_host();
      t_loader();
      t_normal();
      t_wake();
      t_bcast();
      t_mcast();
      report_and_stop();
   end
   initial begin
      repeat (20000) @(posedge clock);
      num_errors++;
      report_and_stop();
   end
endmodule

bind wake_pattern_detector_addr wake_checker u_wake_checker (.clock(clock), .srst(srst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .rx_in(rx_in), .rx_out(rx_out), .ee_in(ee_in),
   .fabric_pause_addr(fabric_pause_addr), .station_addr(station_addr), .irq(irq),
   .power_event_out(power_event_out));
